// [design/pfsm_defs.svh]
`ifndef PFSM_DEFS_SVH
`define PFSM_DEFS_SVH

// register word offsets
`define PFSM_REG_CTRL      4'h0
`define PFSM_REG_AVG       4'h1
`define PFSM_REG_PPR       4'h2
`define PFSM_REG_DEST      4'h3
`define PFSM_REG_STATUS    4'h4
`define PFSM_REG_FREQ      4'h5
`define PFSM_REG_SPEED     4'h6
`define PFSM_REG_GPO       4'h7

// reset values
`define PFSM_CTRL_RST      8'h00
`define PFSM_AVG_RST       7'h01
`define PFSM_PPR_RST       18'h00001
`define PFSM_DEST_RST      16'h0000
`define PFSM_GPO_RST       2'h0

// status word field positions
`define PFSM_ST_FREQ_RUN   4
`define PFSM_ST_SPEED_RUN  5
`define PFSM_ST_GP_B       8
`define PFSM_ST_GP_Z       9
`define PFSM_ST_GP_FUNC    10
`define PFSM_ST_GP_LATCH   11

// setting limits
`define PFSM_AVG_MAX       7'h64
`define PFSM_PPR_MAX       18'h30d40

// timing: base unit time 0.01 s at a 100 ns clock
`define PFSM_UNIT_TIME_NS  10000000
`define PFSM_CLK_PERIOD_NS 100
`define PFSM_DECADE        4'h9

// output scaling per unit time (1/unit and 60/unit)
`define PFSM_HZ_10MS       48'h64
`define PFSM_HZ_100MS      48'ha
`define PFSM_HZ_1S         48'h1
`define PFSM_RPM_10MS      48'h1770
`define PFSM_RPM_100MS     48'h258
`define PFSM_RPM_1S        48'h3c

`define PFSM_DIV_STEPS     6'h2f

`endif

// [design/pfsm_phase_decode.sv]
`timescale 1ns/1ps

module pfsm_phase_decode (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire pfsm_pkg::pfsm_src_t src,
	input  wire logic              a,
	input  wire logic              b,
	output logic                   up,
	output logic                   dn
);
	logic a_q;
	logic b_q;
	logic a_r;
	logic a_f;
	logic b_r;
	logic b_f;
	logic up_d;
	logic dn_d;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= a;
			b_q <= b;
		end
	end

	assign a_r = a & ~a_q;
	assign a_f = ~a & a_q;
	assign b_r = b & ~b_q;
	assign b_f = ~b & b_q;

	// edge to signed step per count source
	always_comb begin
		up_d = 1'b0;
		dn_d = 1'b0;
		case (src)
			pfsm_pkg::PFSM_A1: up_d = a_r;
			pfsm_pkg::PFSM_A2: up_d = a_r | a_f;
			pfsm_pkg::PFSM_P1: begin
				up_d = a_r & ~b;
				dn_d = a_r & b;
			end
			pfsm_pkg::PFSM_P2: begin
				up_d = (a_r | a_f) & ~b;
				dn_d = (a_r | a_f) & b;
			end
			pfsm_pkg::PFSM_CWCCW: begin
				up_d = a_r & ~b_r;
				dn_d = b_r & ~a_r;
			end
			pfsm_pkg::PFSM_Q1: begin
				up_d = a_r & ~b;
				dn_d = a_f & ~b;
			end
			pfsm_pkg::PFSM_Q2: begin
				up_d = (a_r & ~b) | (a_f & b);
				dn_d = (a_f & ~b) | (a_r & b);
			end
			pfsm_pkg::PFSM_Q4: begin
				up_d = (a_r & ~b) | (a_f & b) | (b_r & a) | (b_f & ~a);
				dn_d = (a_f & ~b) | (a_r & b) | (b_f & a) | (b_r & ~a);
			end
			default: begin
				up_d = 1'b0;
				dn_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			up <= 1'b0;
			dn <= 1'b0;
		end else begin
			up <= up_d;
			dn <= dn_d;
		end
	end

endmodule : pfsm_phase_decode

// [design/pfsm_pkg.sv]
package pfsm_pkg;

	typedef struct packed {
		logic [2:0] count_src;
		logic [1:0] unit_sel;
		logic       mode_speed;
		logic       speed_cmd;
		logic       freq_cmd;
	} pfsm_ctrl_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] data;
	} pfsm_dest_t;

	typedef enum logic [1:0] {
		PFSM_IDLE = 2'b00,
		PFSM_RUN  = 2'b01,
		PFSM_DIV  = 2'b11
	} pfsm_state_t;

	typedef enum logic [2:0] {
		PFSM_A1    = 3'h0,
		PFSM_A2    = 3'h1,
		PFSM_P1    = 3'h2,
		PFSM_P2    = 3'h3,
		PFSM_CWCCW = 3'h4,
		PFSM_Q1    = 3'h5,
		PFSM_Q2    = 3'h6,
		PFSM_Q4    = 3'h7
	} pfsm_src_t;

endpackage : pfsm_pkg

// [design/pfsm_top.sv]
`timescale 1ns/1ps
`include "pfsm_defs.svh"

// Summary of operation
// - frequency command on starts measuring and sets frequency running flag.
// - while running, each result goes to destination; averaged over N samples.
// - frequency command off stops measuring and clears running flag.
// - on stop the measured value becomes zero, not written to destination.
// - command raised again while running is ignored.
// - speed mode counts phase A/B pulses and computes speed.
// - each speed result is written to the command's destination.
// - averaging count 1 to 100; 1 means no averaging.
// - unit time selectable as 0.01 s, 0.1 s or 1 s.
// - zero pulses in a unit time give a zero result.
// - counting down gives a negative signed result.
// - pulses per rotation 1 to 200000, used in speed result.
// - unused phase B stays readable as general input, no interrupt.
// - phase Z, function, latch in and both outputs stay general purpose.
// - frequency equals count per unit time over unit time.
// - speed equals 60 times count over unit time times pulses per turn.
// - counting runs continuously so fractions carry into later windows.
// - averaged result stored only once N samples exist.
module pfsm_top #(
	parameter int UNIT_CYCLES = `PFSM_UNIT_TIME_NS / `PFSM_CLK_PERIOD_NS
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [3:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_we,
	input  wire logic                reg_re,
	output logic [31:0]              reg_rdata,
	input  wire logic                phase_a,
	input  wire logic                phase_b,
	input  wire logic                phase_z,
	input  wire logic                func_in,
	input  wire logic                latch_in,
	output logic                     coin1_out,
	output logic                     coin2_out,
	output pfsm_pkg::pfsm_dest_t     dest_wr,
	output logic                     dest_we
);
	localparam int NPIN = 5;

	pfsm_pkg::pfsm_ctrl_t  ctrl_q;
	pfsm_pkg::pfsm_state_t state_q;
	logic [6:0]        avg_q;
	logic [17:0]       ppr_q;
	logic [15:0]       dest_q;
	logic [1:0]        gpo_q;
	logic [NPIN-1:0]   pin_s1_q;
	logic [NPIN-1:0]   pin_s2_q;
	logic [NPIN-1:0]   pin_raw;
	logic              step_up;
	logic              step_dn;
	logic [23:0]       base_cnt_q;
	logic              base_tick;
	logic [3:0]        dec1_q;
	logic [3:0]        dec2_q;
	logic              tick;
	logic signed [23:0] cnt_q;
	logic signed [23:0] step;
	logic signed [23:0] ring_q [0:99];
	logic [6:0]        wp_q;
	logic [6:0]        fill_q;
	logic [6:0]        n_q;
	logic [17:0]       ppr_run_q;
	logic [1:0]        unit_run_q;
	logic              run_speed_q;
	logic signed [31:0] sum_q;
	logic signed [31:0] sum_d;
	logic signed [23:0] oldest;
	logic              cmd_on;
	logic              freq_run;
	logic              speed_run;
	logic [47:0]       num_q;
	logic [25:0]       rem_q;
	logic [24:0]       den_q;
	logic              neg_q;
	logic [5:0]        dstep_q;
	logic [25:0]       rem_sh;
	logic              ge;
	logic [47:0]       scale;
	logic signed [47:0] prod;
	logic [31:0]       quo;
	logic signed [31:0] freq_val_q;
	logic signed [31:0] speed_val_q;
	logic [31:0]       status;
	logic [6:0]        wr_avg;
	logic [17:0]       wr_ppr;

	// two-flop input synchronisers
	assign pin_raw = {latch_in, func_in, phase_z, phase_b, phase_a};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
				end
			end
		end
	endgenerate

	pfsm_phase_decode u_dec (
		.clk (clk),
		.rst (rst),
		.src (pfsm_pkg::pfsm_src_t'(ctrl_q.count_src)),
		.a   (pin_s2_q[0]),
		.b   (pin_s2_q[1]),
		.up  (step_up),
		.dn  (step_dn)
	);

	// unit time ticks: 0.01 s base, then two decades
	assign base_tick = (base_cnt_q == 24'(UNIT_CYCLES - 1));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_cnt_q <= 24'h000000;
			dec1_q     <= 4'h0;
			dec2_q     <= 4'h0;
		end else if (state_q == pfsm_pkg::PFSM_IDLE) begin
			base_cnt_q <= 24'h000000;
			dec1_q     <= 4'h0;
			dec2_q     <= 4'h0;
		end else if (base_tick) begin
			base_cnt_q <= 24'h000000;
			dec1_q     <= (dec1_q == `PFSM_DECADE) ? 4'h0 : dec1_q + 4'h1;
			if (dec1_q == `PFSM_DECADE)
				dec2_q <= (dec2_q == `PFSM_DECADE) ? 4'h0 : dec2_q + 4'h1;
		end else begin
			base_cnt_q <= base_cnt_q + 24'h000001;
		end
	end

	always_comb begin
		case (unit_run_q)
			2'h0:    tick = base_tick;
			2'h1:    tick = base_tick && dec1_q == `PFSM_DECADE;
			default: tick = base_tick && dec1_q == `PFSM_DECADE
				&& dec2_q == `PFSM_DECADE;
		endcase
	end

	// signed pulse accumulator per unit time
	assign step = step_up ? 24'sh000001 : (step_dn ? -24'sh000001 : 24'sh0);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_q <= 24'sh0;
		else if (state_q == pfsm_pkg::PFSM_IDLE)
			cnt_q <= 24'sh0;
		else if (tick)
			cnt_q <= step;
		else
			cnt_q <= cnt_q + step;
	end

	// run control
	assign cmd_on = run_speed_q ? ctrl_q.speed_cmd : ctrl_q.freq_cmd;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q     <= pfsm_pkg::PFSM_IDLE;
			run_speed_q <= 1'b0;
			n_q         <= 7'h01;
			ppr_run_q   <= `PFSM_PPR_RST;
			unit_run_q  <= 2'h0;
		end else begin
			case (state_q)
				pfsm_pkg::PFSM_IDLE: begin
					if (ctrl_q.mode_speed ? ctrl_q.speed_cmd
						: ctrl_q.freq_cmd) begin
						state_q     <= pfsm_pkg::PFSM_RUN;
						run_speed_q <= ctrl_q.mode_speed;
						n_q         <= avg_q;
						ppr_run_q   <= ppr_q;
						unit_run_q  <= ctrl_q.unit_sel;
					end
				end
				pfsm_pkg::PFSM_RUN: begin
					if (!cmd_on)
						state_q <= pfsm_pkg::PFSM_IDLE;
					else if (tick && fill_q + 7'h01 >= n_q)
						state_q <= pfsm_pkg::PFSM_DIV;
				end
				pfsm_pkg::PFSM_DIV: begin
					if (!cmd_on)
						state_q <= pfsm_pkg::PFSM_IDLE;
					else if (dstep_q == 6'h00)
						state_q <= pfsm_pkg::PFSM_RUN;
				end
				default: state_q <= pfsm_pkg::PFSM_IDLE;
			endcase
		end
	end
	// a fresh command while running changes nothing
	assign freq_run  = state_q != pfsm_pkg::PFSM_IDLE && !run_speed_q;
	assign speed_run = state_q != pfsm_pkg::PFSM_IDLE && run_speed_q;

	// sliding window of the last n samples
	assign oldest = (fill_q >= n_q) ? ring_q[wp_q] : 24'sh0;
	assign sum_d  = sum_q + 32'(cnt_q) - 32'(oldest);
	generate
		for (gi = 0; gi < 100; gi++) begin : g_ring
			always_ff @(posedge clk) begin
				if (tick && state_q != pfsm_pkg::PFSM_IDLE
					&& wp_q == 7'(gi))
					ring_q[gi] <= cnt_q;
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_q   <= 7'h00;
			fill_q <= 7'h00;
			sum_q  <= 32'sh0;
		end else if (state_q == pfsm_pkg::PFSM_IDLE) begin
			wp_q   <= 7'h00;
			fill_q <= 7'h00;
			sum_q  <= 32'sh0;
		end else if (tick) begin
			wp_q   <= (wp_q + 7'h01 >= n_q) ? 7'h00 : wp_q + 7'h01;
			fill_q <= (fill_q >= n_q) ? fill_q : fill_q + 7'h01;
			sum_q  <= sum_d;
		end
	end

	// scale: 1/unit for hertz, 60/unit for speed
	always_comb begin
		case ({run_speed_q, unit_run_q})
			3'h0:    scale = `PFSM_HZ_10MS;
			3'h1:    scale = `PFSM_HZ_100MS;
			3'h4:    scale = `PFSM_RPM_10MS;
			3'h5:    scale = `PFSM_RPM_100MS;
			3'h6:    scale = `PFSM_RPM_1S;
			3'h7:    scale = `PFSM_RPM_1S;
			default: scale = `PFSM_HZ_1S;
		endcase
	end
	assign prod = 48'(sum_d) * $signed(scale);

	// restoring divider on magnitudes
	assign rem_sh = {rem_q[24:0], num_q[47]};
	assign ge     = rem_sh >= {1'b0, den_q};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			num_q   <= 48'h0;
			rem_q   <= 26'h0;
			den_q   <= 25'h1;
			neg_q   <= 1'b0;
			dstep_q <= 6'h00;
		end else if (state_q == pfsm_pkg::PFSM_RUN && tick) begin
			num_q   <= prod[47] ? 48'(-prod) : prod;
			neg_q   <= prod[47];
			rem_q   <= 26'h0;
			den_q   <= run_speed_q ? 25'(n_q) * 25'(ppr_run_q)
				: 25'(n_q);
			dstep_q <= `PFSM_DIV_STEPS;
		end else if (state_q == pfsm_pkg::PFSM_DIV) begin
			rem_q   <= ge ? rem_sh - {1'b0, den_q} : rem_sh;
			num_q   <= {num_q[46:0], ge};
			dstep_q <= dstep_q - 6'h01;
		end
	end
	assign quo = ge ? {num_q[30:0], 1'b1} : {num_q[30:0], 1'b0};

	// result store, destination write and zero on stop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freq_val_q  <= 32'sh0;
			speed_val_q <= 32'sh0;
			dest_wr     <= '0;
			dest_we     <= 1'b0;
		end else begin
			dest_we <= 1'b0;
			if (state_q != pfsm_pkg::PFSM_IDLE && !cmd_on) begin
				if (run_speed_q)
					speed_val_q <= 32'sh0;
				else
					freq_val_q <= 32'sh0;
			end else if (state_q == pfsm_pkg::PFSM_DIV
				&& dstep_q == 6'h00) begin
				dest_we      <= 1'b1;
				dest_wr.addr <= dest_q;
				dest_wr.data <= neg_q ? -quo : quo;
				if (run_speed_q)
					speed_val_q <= neg_q ? -quo : quo;
				else
					freq_val_q <= neg_q ? -quo : quo;
			end
		end
	end

	// register writes, settings clamped to their ranges
	assign wr_avg = (reg_wdata == 32'h0) ? 7'h01
		: (reg_wdata > {25'h0, `PFSM_AVG_MAX} ? `PFSM_AVG_MAX
		: reg_wdata[6:0]);
	assign wr_ppr = (reg_wdata == 32'h0) ? 18'h00001
		: (reg_wdata > {14'h0, `PFSM_PPR_MAX} ? `PFSM_PPR_MAX
		: reg_wdata[17:0]);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `PFSM_CTRL_RST;
			avg_q  <= `PFSM_AVG_RST;
			ppr_q  <= `PFSM_PPR_RST;
			dest_q <= `PFSM_DEST_RST;
			gpo_q  <= `PFSM_GPO_RST;
		end else if (reg_we) begin
			case (reg_addr)
				`PFSM_REG_CTRL: ctrl_q <= reg_wdata[7:0];
				`PFSM_REG_AVG:  avg_q  <= wr_avg;
				`PFSM_REG_PPR:  ppr_q  <= wr_ppr;
				`PFSM_REG_DEST: dest_q <= reg_wdata[15:0];
				`PFSM_REG_GPO:  gpo_q  <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	assign coin1_out = gpo_q[0];
	assign coin2_out = gpo_q[1];

	always_comb begin
		status = 32'h0;
		status[`PFSM_ST_FREQ_RUN]  = freq_run;
		status[`PFSM_ST_SPEED_RUN] = speed_run;
		status[`PFSM_ST_GP_B]      = pin_s2_q[1];
		status[`PFSM_ST_GP_Z]      = pin_s2_q[2];
		status[`PFSM_ST_GP_FUNC]   = pin_s2_q[3];
		status[`PFSM_ST_GP_LATCH]  = pin_s2_q[4];
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_re) begin
			case (reg_addr)
				`PFSM_REG_CTRL:   reg_rdata <= {24'h0, ctrl_q};
				`PFSM_REG_AVG:    reg_rdata <= {25'h0, avg_q};
				`PFSM_REG_PPR:    reg_rdata <= {14'h0, ppr_q};
				`PFSM_REG_DEST:   reg_rdata <= {16'h0, dest_q};
				`PFSM_REG_STATUS: reg_rdata <= status;
				`PFSM_REG_FREQ:   reg_rdata <= freq_val_q;
				`PFSM_REG_SPEED:  reg_rdata <= speed_val_q;
				`PFSM_REG_GPO:    reg_rdata <= {30'h0, gpo_q};
				default:          reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

endmodule : pfsm_top

// [tb/pfsm_pulse_gen.sv]
`timescale 1ns/1ps

module pfsm_pulse_gen (
	input  wire logic        clk,
	input  wire logic        en,
	input  wire logic        dn,
	input  wire logic [15:0] quarter,
	output logic             pa,
	output logic             pb
);
	logic [15:0] cnt;
	logic [1:0]  ph;

	initial begin
		cnt = 16'h0;
		ph  = 2'h0;
	end

	// one quadrature step per quarter period, a leads b going up
	always @(posedge clk) begin
		if (!en) begin
			cnt <= 16'h0;
		end else if (cnt + 16'h1 >= quarter) begin
			cnt <= 16'h0;
			ph  <= dn ? ph - 2'h1 : ph + 2'h1;
		end else begin
			cnt <= cnt + 16'h1;
		end
	end

	assign pa = ph[1] ^ ph[0];
	assign pb = ph[1];
endmodule : pfsm_pulse_gen

// [tb/pfsm_top_sva.sv]
`timescale 1ns/1ps

module pfsm_top_chk (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic [3:0]           reg_addr,
	input wire logic [31:0]          reg_wdata,
	input wire logic                 reg_we,
	input wire logic                 reg_re,
	input wire logic [31:0]          reg_rdata,
	input wire logic                 phase_z,
	input wire logic                 func_in,
	input wire logic                 latch_in,
	input wire logic                 coin1_out,
	input wire logic                 coin2_out,
	input wire pfsm_pkg::pfsm_dest_t dest_wr,
	input wire logic                 dest_we
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_run_flag_set: assert property (
		(reg_we && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h1) ##3
		(reg_re && reg_addr == 4'h4) |=> reg_rdata[4])
		else $error("freq running flag not set");
	a_stop_flag_clear: assert property (
		(reg_we && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h0) ##[3:6]
		(reg_re && reg_addr == 4'h4) |=> reg_rdata[5:4] == 2'h0)
		else $error("running flag still set");
	a_stop_value_zero: assert property (
		(reg_we && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h0) ##[3:6]
		(reg_re && reg_addr == 4'h5) |=> reg_rdata == 32'h0)
		else $error("freq value not zero after stop");
	a_stop_quiet: assert property (
		(reg_we && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h0)
		|-> ##3 (!dest_we) [*8])
		else $error("result written after stop");
	a_result_pulse: assert property (dest_we |=> !dest_we)
		else $error("result strobe longer than one cycle");
	a_result_hold: assert property (!dest_we |-> $stable(dest_wr))
		else $error("result changed without strobe");
	a_gpo_follow: assert property (
		(reg_we && reg_addr == 4'h7)
		|=> {coin2_out, coin1_out} == $past(reg_wdata[1:0]))
		else $error("general outputs do not follow write");
	a_gp_inputs: assert property (
		(phase_z && func_in && latch_in) [*6] ##0
		(reg_re && reg_addr == 4'h4) |=> reg_rdata[11:9] == 3'h7)
		else $error("general inputs not visible");
	a_avg_range: assert property (
		(reg_re && reg_addr == 4'h1)
		|=> (reg_rdata >= 32'h1 && reg_rdata <= 32'h64))
		else $error("averaging count out of range");
	a_ppr_range: assert property (
		(reg_re && reg_addr == 4'h2)
		|=> (reg_rdata >= 32'h1 && reg_rdata <= 32'h30d40))
		else $error("pulses per turn out of range");
endmodule : pfsm_top_chk

bind pfsm_top pfsm_top_chk pfsm_top_chk_inst (
	.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
	.phase_z(phase_z), .func_in(func_in), .latch_in(latch_in),
	.coin1_out(coin1_out), .coin2_out(coin2_out),
	.dest_wr(dest_wr), .dest_we(dest_we)
);

// [tb/testbench.sv]
`timescale 1ns/1ps

module testbench;
	localparam int UC = 100;
	logic                 clk, rst, reg_we, reg_re, re_d, armed;
	logic                 phase_a, phase_b, phase_z, func_in, latch_in;
	logic                 coin1_out, coin2_out, dest_we, pg_en, pg_dn;
	logic [3:0]           reg_addr;
	logic [31:0]          reg_wdata, reg_rdata, ppr;
	logic [15:0]          pg_q, dst;
	logic [63:0]          e;
	logic [63:0]          rq[$];
	pfsm_pkg::pfsm_dest_t dest_wr;
	pfsm_pkg::pfsm_dest_t dq[$];
	int                   mismatches, cmp_count, cyc, qv;

	pfsm_top #(.UNIT_CYCLES(UC)) pfsm_top_inst (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.phase_a(phase_a), .phase_b(phase_b), .phase_z(phase_z),
		.func_in(func_in), .latch_in(latch_in), .coin1_out(coin1_out),
		.coin2_out(coin2_out), .dest_wr(dest_wr), .dest_we(dest_we)
	);
	pfsm_pulse_gen pfsm_pulse_gen_inst (
		.clk(clk), .en(pg_en), .dn(pg_dn), .quarter(pg_q),
		.pa(phase_a), .pb(phase_b)
	);

	always #50 clk = ~clk;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] v,
		input logic [31:0] m);
		rq.push_back({m, v & m});
		@(posedge clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
	endtask : rd

	// start, skip warm-up result, expect k results, stop
	task automatic run(input logic [7:0] c, input logic [31:0] v, input int k);
		wr(4'h0, {24'h0, c});
		@(posedge clk);
		rd(4'h4, 32'h10 << c[2], 32'h30);
		armed = 1'b0;
		@(negedge clk iff dest_we === 1'b1);
		@(posedge clk);
		repeat (k) dq.push_back({dst, v});
		armed = 1'b1;
		wr(4'h0, {24'h0, c});
		repeat (k) begin
			@(negedge clk iff dest_we === 1'b1);
			@(posedge clk);
		end
		rd(4'h5 + {3'h0, c[2]}, v, '1);
		wr(4'h0, {24'h0, c & 8'hfc});
		@(posedge clk);
		rd(4'h4, 32'h0, 32'h30);
		rd(4'h5 + {3'h0, c[2]}, 32'h0, '1);
		repeat (3 * UC) @(posedge clk);
		$display("test run %h done", c);
	endtask : run

	task automatic set_pulses(input logic dn_i);
		qv = 1;
		repeat ($urandom % 3) qv = qv * 5;
		pg_q  <= qv[15:0];
		pg_dn <= dn_i;
		pg_en <= 1'b1;
		repeat (200) @(posedge clk);
	endtask : set_pulses

	always @(posedge clk) re_d <= reg_re;

	always @(negedge clk) begin
		if (re_d) begin
			e = rq.pop_front();
			check({32'h0, reg_rdata & e[63:32]}, {32'h0, e[31:0]});
		end
		if (dest_we === 1'b1 && armed) begin
			if (dq.size() == 0)
				check(64'h1, 64'h0);
			else
				check({16'h0, dest_wr}, {16'h0, dq.pop_front()});
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{reg_we, reg_re, re_d, armed, pg_en, pg_dn} = 6'h0;
		{phase_z, func_in, latch_in} = 3'h0;
		reg_addr  = 4'h0;
		reg_wdata = 32'h0;
		pg_q      = 16'h5;
		mismatches = 0;
		cmp_count  = 0;
		cyc        = 0;
		qv = $urandom(27);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(4'h1, 32'h1, '1);
		rd(4'h2, 32'h1, '1);
		rd(4'h9, 32'h0, '1);
		wr(4'h1, 32'h0);
		rd(4'h1, 32'h1, '1);
		wr(4'h1, 32'hc8);
		rd(4'h1, 32'h64, '1);
		wr(4'h2, 32'h0);
		rd(4'h2, 32'h1, '1);
		wr(4'h2, 32'h40000);
		rd(4'h2, 32'h30d40, '1);
		wr(4'h7, 32'h3);
		@(negedge clk);
		check({62'h0, coin2_out, coin1_out}, 64'h3);
		@(posedge clk);
		{phase_z, func_in, latch_in} <= 3'h7;
		repeat (8) @(posedge clk);
		rd(4'h4, 32'he00, 32'hf00);
		{phase_z, func_in, latch_in} <= 3'h0;
		repeat (8) @(posedge clk);
		rd(4'h4, 32'h0, 32'hf00);
		$display("test registers done");
		dst = 16'($urandom);
		wr(4'h3, {16'h0, dst});
		for (int u = 0; u < 3; u++) begin
			set_pulses(1'b0);
			wr(4'h1, (u == 2) ? 32'h1 : 32'h4);
			run({3'h5, 2'(u), 3'h1}, 32'(2500 / qv), 2);
		end
		wr(4'h1, 32'h1);
		run(8'he1, 32'(10000 / qv), 2);
		pg_en <= 1'b0;
		repeat (200) @(posedge clk);
		wr(4'h1, 32'h2);
		run(8'ha1, 32'h0, 2);
		ppr = $urandom % 600 + 1;
		wr(4'h2, ppr);
		set_pulses(1'b1);
		wr(4'h1, 32'h3);
		run(8'hae, -32'(150000 / (qv * ppr)), 2);
		give_verdict();
	end
endmodule : testbench
